//--- pkg/status_block_map.vh
// Purpose: Offsets, field positions, reset values and timing counts of the status block builder.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Definitions only.
`ifndef STATUS_BLOCK_MAP_VH
`define STATUS_BLOCK_MAP_VH

// Register byte offsets.
`define OFF_CTRL        8'h00
`define OFF_CFG_FRAME   8'h04
`define OFF_CFG_RATE    8'h08
`define OFF_CFG_PACKET  8'h0c
`define OFF_CFG_TIMING  8'h10
`define OFF_ERR         8'h14
`define OFF_EFFECTIVE   8'h18
`define OFF_TX_STATUS   8'h1c

// Length byte values that mark the two status layouts.
`define LEN_STATUS_A    8'hfc
`define LEN_STATUS_B    8'hfd

// Control fields.
`define CTRL_LAYOUT_B   0
`define CTRL_ALTERNATE  1

// Error word bit positions.
`define EB_TERM         0
`define EB_BAUD         1
`define EB_PARITY       2
`define EB_DATA         3
`define EB_STOP         4
`define EB_HANDSHAKE    5
`define EB_TERM_COUNT   6
`define EB_PACKET       7
`define EB_RX_TIMEOUT   8
`define EB_RX_GAP       9
`define EB_WR_TIMEOUT   10
`define EB_OVERRUN      15

// Termination type bits: zero means stream mode.
`define TT_CHAR         0
`define TT_PACKET       1
`define TT_TIMEOUT      2
`define TT_GAP          3

// Reset values of the configuration registers.
`define RST_CTRL        32'h0000_0000
`define RST_CFG_FRAME   32'h184e_4e00
`define RST_CFG_RATE    32'h0100_2580
`define RST_CFG_PACKET  32'h1388_0001
`define RST_CFG_TIMING  32'h0064_0064

// Fallback values and limits.
`define BAUD_FALLBACK   24'h002580
`define WR_TIMEOUT_MS   16'h1388
`define WORD_LEN_DEF    4'h8
`define MAX_PACKET      16'h1000
`define MAX_TERM_COUNT  8'h0c
`define MAX_WR_CHARS    4'ha

// Clock rate and the derived cycles per millisecond.
`define CLK_HZ          250000000
`define MS_PER_S        1000
`define MS_CYCLES       (`CLK_HZ / `MS_PER_S)

`endif

//--- design/status_block_builder.v
// Purpose: Builds the 16-byte status blocks of a serial gateway and paces port writes.
// Assumes: All inputs come from logic on clk_in; registers reached over APB3.
// Notes:   Words sit little endian in the image: low byte at the lower offset.
//
// Overview of operation
// - With no receive data pending, a scan loads a status block into the image.
// - The length byte holds 252 or 253, choosing one of two layouts.
// - Layout 252: cycle, sent, received, parsed, errors, error word, transmit state.
// - Layout 253: cycle, rx state, rx chars, rx blocks, tx chars, tx blocks, tx state.
// - The sequence number changes on every scan; byte 0 of each status block carries it.
// - Termination type above 15 sets bit 0; port uses stream mode.
// - Invalid baud rate sets bit 1; port runs at 9600 baud.
// - Parity chosen by first letter; invalid letter sets bit 2, no parity used.
// - Data bits 5 to 8 accepted; otherwise bit 3 set and 8 used.
// - Stop bits 1 or 2 accepted; otherwise bit 4 set and 1 used.
// - Handshake chosen by first letter; invalid sets bit 5, none used.
// - With char ending selected, termination character count must be 1 to 12; else bit 6, no char ending.
// - With packet ending selected, packet length must be 1 to 4096; else bit 7, packet ending off.
// - Zero receive timeout sets bit 8; timeout ending not used.
// - Zero intercharacter delay sets bit 9; gap ending not used.
// - Zero write timeout sets bit 10; 5000 ms used instead.
// - Discarded receive data sets overrun bit 15.
// - With no errors the error word reads zero.
// - A write block with data arriving while idle starts transmission at once with its timing; one arriving while busy is ignored.
// - Transmit state is nonzero while sending and zero once finished.
`timescale 1ns/100ps
`include "status_block_map.vh"

module status_block_builder #(
  parameter MS_CYCLES = `MS_CYCLES
) (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  input  wire        scan_tick_in,
  input  wire        rx_pending_in,
  input  wire        blocks_sent_in,
  input  wire        blocks_recv_in,
  input  wire        blocks_parsed_in,
  input  wire        block_error_in,
  input  wire        rx_char_in,
  input  wire        rx_block_in,
  input  wire [15:0] rx_state_in,
  input  wire        rx_discard_in,
  input  wire        wr_start_in,
  input  wire [3:0]  wr_count_in,
  input  wire [7:0]  wr_gap_ms_in,
  input  wire [79:0] wr_data_in,
  input  wire        tx_done_in,
  output reg         tx_req_out,
  output reg  [7:0]  tx_byte_out,
  output reg         tx_busy_out,
  output reg  [127:0] image_out,
  output reg         status_block_out,
  output reg  [7:0]  seq_out,
  output reg  [3:0]  eff_term_type_out,
  output reg  [23:0] eff_baud_out,
  output reg  [2:0]  eff_parity_out,
  output reg  [3:0]  eff_word_len_out,
  output reg         eff_two_stop_out,
  output reg  [1:0]  eff_handshake_out,
  output reg         term_char_en_out,
  output reg         term_packet_en_out,
  output reg         term_timeout_en_out,
  output reg         term_gap_en_out,
  output reg  [15:0] eff_wr_timeout_out
);

  localparam ST_IDLE = 2'b00;
  localparam ST_REQ  = 2'b01;
  localparam ST_WAIT = 2'b10;
  localparam ST_GAP  = 2'b11;
  localparam N_CNT   = 9;

  reg  [31:0] ctrl_ff;
  reg  [31:0] cfg_frame_ff;
  reg  [31:0] cfg_rate_ff;
  reg  [31:0] cfg_packet_ff;
  reg  [31:0] cfg_timing_ff;
  reg         overrun_ff;
  reg         alt_ff;
  reg  [1:0]  tx_st_ff;
  reg  [3:0]  tx_left_ff;
  reg  [3:0]  tx_idx_ff;
  reg  [7:0]  tx_gap_ff;
  reg  [79:0] tx_data_ff;
  reg  [17:0] ms_tick_ff;
  reg  [15:0] ms_elapsed_ff;
  reg  [7:0]  gap_left_ff;

  wire [7:0]  term_type  = cfg_frame_ff[7:0];
  wire [7:0]  par_letter = cfg_frame_ff[15:8] & 8'hdf;
  wire [7:0]  hs_letter  = cfg_frame_ff[23:16] & 8'hdf;
  wire [3:0]  word_len   = cfg_frame_ff[27:24];
  wire [3:0]  stop_cnt   = cfg_frame_ff[31:28];
  wire [23:0] baud       = cfg_rate_ff[23:0];
  wire [7:0]  term_cnt   = cfg_rate_ff[31:24];
  wire [15:0] pkt_len    = cfg_packet_ff[15:0];
  wire [15:0] wr_to      = cfg_packet_ff[31:16];
  wire [15:0] rx_to      = cfg_timing_ff[15:0];
  wire [15:0] rx_gap     = cfg_timing_ff[31:16];

  // Configuration checks; each failed check picks its documented fallback.
  reg         bad_term;
  reg         bad_baud;
  reg         bad_parity;
  reg  [2:0]  parity_code;
  reg         bad_handshake;
  reg  [1:0]  hs_code;
  wire [3:0]  nxt_term_type;
  wire        bad_word_length_flag;
  wire        bad_stop_count_flag;
  wire        bad_count;
  wire        bad_packet_size_flag;
  wire        rx_overrun_flag;
  wire [15:0] err_word;

  always @* begin
    bad_term = (term_type > 8'h0f);
    case (baud)
      24'h00006e, 24'h00012c, 24'h000258, 24'h0004b0, 24'h000960,
      24'h0012c0, 24'h002580, 24'h004b00, 24'h009600, 24'h00e100,
      24'h01c200: bad_baud = 1'b0;
      default:    bad_baud = 1'b1;
    endcase
    bad_parity = 1'b0;
    case (par_letter)
      8'h4e:   parity_code = 3'h0;
      8'h45:   parity_code = 3'h1;
      8'h4f:   parity_code = 3'h2;
      8'h4d:   parity_code = 3'h3;
      8'h53:   parity_code = 3'h4;
      default: begin
        parity_code = 3'h0;
        bad_parity  = 1'b1;
      end
    endcase
    bad_handshake = 1'b0;
    case (hs_letter)
      8'h4e:   hs_code = 2'h0;
      8'h52:   hs_code = 2'h1;
      8'h44:   hs_code = 2'h2;
      8'h58:   hs_code = 2'h3;
      default: begin
        hs_code       = 2'h0;
        bad_handshake = 1'b1;
      end
    endcase
  end

  assign nxt_term_type        = bad_term ? 4'h0 : term_type[3:0];
  assign bad_word_length_flag = (word_len < 4'h5) || (word_len > 4'h8);
  assign bad_stop_count_flag  = (stop_cnt != 4'h1) && (stop_cnt != 4'h2);
  // Count and length limits only matter when that termination is selected.
  assign bad_count = nxt_term_type[`TT_CHAR] &&
                     ((term_cnt == 8'h00) || (term_cnt > `MAX_TERM_COUNT));
  assign bad_packet_size_flag = nxt_term_type[`TT_PACKET] &&
                     ((pkt_len == 16'h0000) || (pkt_len > `MAX_PACKET));
  assign rx_overrun_flag = overrun_ff;

  // Spare bits 11 to 14 are tied low; an error-free setup reads all zero.
  assign err_word = {rx_overrun_flag, 4'h0,
                     (wr_to == 16'h0000), (rx_gap == 16'h0000),
                     (rx_to == 16'h0000), bad_packet_size_flag,
                     bad_count, bad_handshake, bad_stop_count_flag,
                     bad_word_length_flag, bad_parity, bad_baud, bad_term};

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      eff_term_type_out   <= 4'h0;
      eff_baud_out        <= `BAUD_FALLBACK;
      eff_parity_out      <= 3'h0;
      eff_word_len_out    <= `WORD_LEN_DEF;
      eff_two_stop_out    <= 1'b0;
      eff_handshake_out   <= 2'h0;
      term_char_en_out    <= 1'b0;
      term_packet_en_out  <= 1'b0;
      term_timeout_en_out <= 1'b0;
      term_gap_en_out     <= 1'b0;
      eff_wr_timeout_out  <= `WR_TIMEOUT_MS;
    end else begin
      eff_term_type_out   <= nxt_term_type;
      eff_baud_out        <= bad_baud ? `BAUD_FALLBACK : baud;
      eff_parity_out      <= parity_code;
      eff_word_len_out    <= bad_word_length_flag ? `WORD_LEN_DEF : word_len;
      eff_two_stop_out    <= (stop_cnt == 4'h2);
      eff_handshake_out   <= hs_code;
      term_char_en_out    <= nxt_term_type[`TT_CHAR] && !bad_count;
      term_packet_en_out  <= nxt_term_type[`TT_PACKET] && !bad_packet_size_flag;
      term_timeout_en_out <= nxt_term_type[`TT_TIMEOUT] && (rx_to != 16'h0000);
      term_gap_en_out     <= nxt_term_type[`TT_GAP] && (rx_gap != 16'h0000);
      eff_wr_timeout_out  <= (wr_to == 16'h0000) ? `WR_TIMEOUT_MS : wr_to;
    end
  end

  // Event counters, one per counted status field (nine, none for the error word, rx state or tx state); each wraps at 16 bits.
  wire [N_CNT-1:0]    cnt_ev;
  wire [16*N_CNT-1:0] cnt_w;
  wire                tx_char_ev = (tx_st_ff == ST_WAIT) && tx_done_in;
  wire                tx_last    = tx_char_ev && (tx_left_ff == 4'h1);

  assign cnt_ev = {tx_last, tx_char_ev, rx_block_in, rx_char_in, block_error_in,
                   blocks_parsed_in, blocks_recv_in, blocks_sent_in, scan_tick_in};

  genvar gi;
  generate
    for (gi = 0; gi < N_CNT; gi = gi + 1) begin : g_cnt
      reg [15:0] c_ff;
      always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          c_ff <= 16'h0000;
        end else if (cnt_ev[gi]) begin
          c_ff <= c_ff + 16'h0001;
        end
      end
      assign cnt_w[16*gi +: 16] = c_ff;
    end
  endgenerate

  // Transmit pacing: one character request, wait for the serializer, then the gap.
  wire        ms_wrap = (ms_tick_ff == MS_CYCLES[17:0] - 18'h00001);
  wire        tx_abort = (tx_st_ff != ST_IDLE) && (ms_elapsed_ff >= eff_wr_timeout_out);
  wire [15:0] tx_state = {14'h0000, tx_st_ff};
  wire [3:0]  start_cnt = (wr_count_in > `MAX_WR_CHARS) ? `MAX_WR_CHARS : wr_count_in;
  reg  [1:0]  nxt_tx_st;

  always @* begin
    nxt_tx_st = tx_st_ff;
    case (tx_st_ff)
      ST_IDLE: if (wr_start_in && (wr_count_in != 4'h0)) nxt_tx_st = ST_REQ;
      ST_REQ:  nxt_tx_st = ST_WAIT;
      ST_WAIT: begin
        if (tx_last) begin
          nxt_tx_st = ST_IDLE;
        end else if (tx_done_in) begin
          nxt_tx_st = (tx_gap_ff == 8'h00) ? ST_REQ : ST_GAP;
        end
      end
      default: if ((gap_left_ff == 8'h00) && ms_wrap) nxt_tx_st = ST_REQ;
    endcase
    // A serializer that never answers would leave the port busy for good.
    if (tx_abort) nxt_tx_st = ST_IDLE;
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_st_ff      <= ST_IDLE;
      tx_left_ff    <= 4'h0;
      tx_idx_ff     <= 4'h0;
      tx_gap_ff     <= 8'h00;
      tx_data_ff    <= 80'h0;
      ms_tick_ff    <= 18'h00000;
      ms_elapsed_ff <= 16'h0000;
      gap_left_ff   <= 8'h00;
      tx_req_out    <= 1'b0;
      tx_byte_out   <= 8'h00;
      tx_busy_out   <= 1'b0;
    end else begin
      tx_st_ff    <= nxt_tx_st;
      tx_req_out  <= (nxt_tx_st == ST_REQ);
      tx_busy_out <= (nxt_tx_st != ST_IDLE);
      // The index steps with the event so a zero gap sends the next byte; the wrap keeps it in range.
      tx_byte_out <= tx_data_ff[8*((tx_idx_ff + {3'h0, tx_char_ev}) % 4'ha) +: 8];
      ms_tick_ff  <= (ms_wrap || tx_char_ev || (tx_st_ff == ST_IDLE)) ? 18'h00000
                                                                       : ms_tick_ff + 18'h00001;
      if (tx_st_ff == ST_IDLE) begin
        ms_elapsed_ff <= 16'h0000;
        if (wr_start_in && (wr_count_in != 4'h0)) begin
          tx_left_ff <= start_cnt;
          tx_idx_ff  <= 4'h0;
          tx_gap_ff  <= wr_gap_ms_in;
          tx_data_ff <= wr_data_in;
          tx_byte_out <= wr_data_in[7:0];
        end
      end else if (ms_wrap) begin
        ms_elapsed_ff <= ms_elapsed_ff + 16'h0001;
      end
      if (tx_char_ev) begin
        tx_left_ff  <= tx_left_ff - 4'h1;
        tx_idx_ff   <= tx_idx_ff + 4'h1;
        gap_left_ff <= tx_gap_ff - 8'h01;
        ms_elapsed_ff <= 16'h0000;
      end else if ((tx_st_ff == ST_GAP) && ms_wrap && (gap_left_ff != 8'h00)) begin
        gap_left_ff <= gap_left_ff - 8'h01;
      end
    end
  end

  // Image assembly on each scan.
  wire        use_b = ctrl_ff[`CTRL_ALTERNATE] ? alt_ff : ctrl_ff[`CTRL_LAYOUT_B];
  wire [15:0] w_cycle = cnt_w[15:0];
  wire [95:0] body_a = {tx_state, err_word, cnt_w[79:64], cnt_w[63:48],
                        cnt_w[47:32], cnt_w[31:16]};
  wire [95:0] body_b = {tx_state, cnt_w[143:128], cnt_w[127:112], cnt_w[111:96],
                        cnt_w[95:80], rx_state_in};

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      image_out        <= 128'h0;
      status_block_out <= 1'b0;
      seq_out          <= 8'h00;
      alt_ff           <= 1'b0;
    end else if (scan_tick_in) begin
      seq_out <= seq_out + 8'h01;
      // Receive blocks take the image when data is pending; this block leaves it alone.
      status_block_out <= !rx_pending_in;
      if (!rx_pending_in) begin
        alt_ff    <= !alt_ff;
        image_out <= {use_b ? body_b : body_a, w_cycle,
                      use_b ? `LEN_STATUS_B : `LEN_STATUS_A,
                      seq_out + 8'h01};
      end
    end
  end

  // APB slave: data and ready are set up in the setup cycle, so every access takes one wait-free cycle.
  wire        setup  = psel_in && !penable_in;
  wire        access = psel_in && penable_in && pready_out;
  wire        wr_acc = access && pwrite_in && !pslverr_out;
  reg  [31:0] rd_mux;
  reg         unmapped;

  always @* begin
    unmapped = 1'b0;
    if (paddr_in == `OFF_CTRL) begin
      rd_mux = ctrl_ff;
    end else if (paddr_in == `OFF_CFG_FRAME) begin
      rd_mux = cfg_frame_ff;
    end else if (paddr_in == `OFF_CFG_RATE) begin
      rd_mux = cfg_rate_ff;
    end else if (paddr_in == `OFF_CFG_PACKET) begin
      rd_mux = cfg_packet_ff;
    end else if (paddr_in == `OFF_CFG_TIMING) begin
      rd_mux = cfg_timing_ff;
    end else if (paddr_in == `OFF_ERR) begin
      rd_mux = {16'h0000, err_word};
    end else if (paddr_in == `OFF_EFFECTIVE) begin
      rd_mux = {6'h00, eff_term_type_out, eff_handshake_out, eff_two_stop_out,
                eff_parity_out, eff_word_len_out, term_gap_en_out, term_timeout_en_out,
                term_packet_en_out, term_char_en_out, 8'h00};
    end else if (paddr_in == `OFF_TX_STATUS) begin
      rd_mux = {tx_state, seq_out, 4'h0, tx_left_ff};
    end else begin
      rd_mux   = 32'h0000_0000;
      unmapped = 1'b1;
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out    <= 32'h0000_0000;
      pready_out    <= 1'b0;
      pslverr_out   <= 1'b0;
      ctrl_ff       <= `RST_CTRL;
      cfg_frame_ff  <= `RST_CFG_FRAME;
      cfg_rate_ff   <= `RST_CFG_RATE;
      cfg_packet_ff <= `RST_CFG_PACKET;
      cfg_timing_ff <= `RST_CFG_TIMING;
      overrun_ff    <= 1'b0;
    end else begin
      pready_out  <= setup;
      pslverr_out <= setup && unmapped;
      prdata_out  <= (setup && !pwrite_in) ? rd_mux : 32'h0000_0000;
      if (wr_acc) begin
        if (paddr_in == `OFF_CTRL) begin
          ctrl_ff <= {30'h0, pwdata_in[1:0]};
        end else if (paddr_in == `OFF_CFG_FRAME) begin
          cfg_frame_ff <= pwdata_in;
        end else if (paddr_in == `OFF_CFG_RATE) begin
          cfg_rate_ff <= pwdata_in;
        end else if (paddr_in == `OFF_CFG_PACKET) begin
          cfg_packet_ff <= pwdata_in;
        end else if (paddr_in == `OFF_CFG_TIMING) begin
          cfg_timing_ff <= pwdata_in;
        end
      end
      // A discard in the clearing cycle keeps the flag set.
      if (rx_discard_in) begin
        overrun_ff <= 1'b1;
      end else if (wr_acc && (paddr_in == `OFF_ERR) && pwdata_in[`EB_OVERRUN]) begin
        overrun_ff <= 1'b0;
      end
    end
  end

endmodule // status_block_builder

//--- tb/serial_sink.sv
// Purpose: Serializer stand-in that answers each character request after a delay.
// Assumes: One request pulse per character on clk_in.
// Notes:   Keeps the last four characters and a count for the bench.
`timescale 1ns/100ps
module serial_sink #(
  parameter DELAY = 5
) (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        tx_req_in,
  input  wire [7:0]  tx_byte_in,
  output reg         tx_done_out,
  output reg  [31:0] sent_out,
  output reg  [7:0]  count_out
);
  reg [7:0] wait_ff;
  // A slow answer keeps the builder in its wait state long enough to be scanned.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_ff     <= 8'h00;
      tx_done_out <= 1'b0;
      sent_out    <= 32'h0;
      count_out   <= 8'h00;
    end else begin
      tx_done_out <= (wait_ff == 8'h01);
      if (tx_req_in) begin
        wait_ff   <= DELAY[7:0];
        sent_out  <= {sent_out[23:0], tx_byte_in};
        count_out <= count_out + 8'h01;
      end else if (wait_ff != 8'h00) begin
        wait_ff <= wait_ff - 8'h01;
      end
    end
  end
endmodule // serial_sink

//--- tb/status_block_builder_asserts.sv
// Purpose: Port-level checks of the status block builder.
// Assumes: Single clock domain, reset active low.
// Notes:   Attached by bind at the foot of this file.
`timescale 1ns/100ps
`include "status_block_map.vh"
module status_block_builder_asserts (
  input wire         clk_in,
  input wire         rst_n_in,
  input wire         psel_in,
  input wire         penable_in,
  input wire         pready_out,
  input wire         pslverr_out,
  input wire         scan_tick_in,
  input wire         rx_pending_in,
  input wire         wr_start_in,
  input wire [3:0]   wr_count_in,
  input wire         tx_busy_out,
  input wire         tx_req_out,
  input wire [127:0] image_out,
  input wire         status_block_out,
  input wire [7:0]   seq_out,
  input wire [23:0]  eff_baud_out,
  input wire [3:0]   eff_word_len_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_ready_after_setup:
    assert property (psel_in && !penable_in |=> pready_out)
    else $error("No ready after an APB setup cycle.");
  a_seq_bumps:
    assert property (scan_tick_in |=> seq_out == $past(seq_out) + 8'h01)
    else $error("Sequence number did not advance.");
  a_length_byte:
    assert property (scan_tick_in && !rx_pending_in |=> status_block_out &&
      (image_out[15:8] == `LEN_STATUS_A || image_out[15:8] == `LEN_STATUS_B))
    else $error("Status block missing or length byte wrong.");
  a_pending_hold:
    assert property (scan_tick_in && rx_pending_in |=> !status_block_out && $stable(image_out))
    else $error("Image changed while receive data was pending.");
  a_spare_bits_zero:
    assert property (status_block_out && image_out[15:8] == `LEN_STATUS_A
      |-> image_out[110:107] == 4'h0)
    else $error("Spare error bits not zero.");
  a_tx_state_word:
    assert property (scan_tick_in && !rx_pending_in
      |=> (image_out[127:112] != 16'h0000) == $past(tx_busy_out))
    else $error("Transmit state disagrees with busy.");
  a_tx_start:
    assert property (wr_start_in && wr_count_in != 4'h0 && !tx_busy_out
      |=> tx_req_out && tx_busy_out)
    else $error("Write did not start at once.");
  a_baud_legal:
    assert property (eff_baud_out inside {24'h00006e, 24'h00012c, 24'h000258, 24'h0004b0,
      24'h000960, 24'h0012c0, 24'h002580, 24'h004b00, 24'h009600, 24'h00e100, 24'h01c200})
    else $error("Effective baud rate not a legal rate.");
  a_word_len_range:
    assert property (eff_word_len_out inside {[4'h5:4'h8]})
    else $error("Effective word length out of range.");
  cover property (scan_tick_in && rx_pending_in);
  cover property ($rose(tx_busy_out));
  cover property (pslverr_out);
endmodule // status_block_builder_asserts
bind status_block_builder status_block_builder_asserts chk_u (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .scan_tick_in(scan_tick_in),
  .rx_pending_in(rx_pending_in), .wr_start_in(wr_start_in), .wr_count_in(wr_count_in),
  .tx_busy_out(tx_busy_out), .tx_req_out(tx_req_out), .image_out(image_out),
  .status_block_out(status_block_out), .seq_out(seq_out), .eff_baud_out(eff_baud_out),
  .eff_word_len_out(eff_word_len_out));

//--- tb/status_block_builder_bench.sv
// Purpose: Self-checking bench of the status block builder.
// Assumes: APB master here, serializer stand-in as partner.
// Notes:   A short millisecond keeps the character gap brief.
`timescale 1ns/100ps
`include "status_block_map.vh"
module status_block_builder_bench;
  reg          clk_in, rst_n_in, psel, penable, pwrite, scan, pend, wr_start;
  reg  [7:0]   paddr, wr_gap;
  reg  [31:0]  pwdata, rd;
  reg  [6:0]   ev;
  reg  [15:0]  rx_state;
  reg  [3:0]   wr_count;
  reg  [79:0]  wr_data;
  reg          err;
  reg  [7:0]   eseq, ca [0:9], cb [0:9];
  reg  [31:0]  cd [0:9], rv [0:4];
  wire [31:0]  prdata, sent;
  wire [127:0] image;
  wire [23:0]  baud;
  wire [15:0]  wr_to;
  wire [7:0]   tx_byte, seq, cnt;
  wire [3:0]   wlen;
  wire         pready, pslverr, tx_done, tx_req, tx_busy, sblk, two_stop;
  int          fails, checks_done, nscan;

  status_block_builder #(.MS_CYCLES(10)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .scan_tick_in(scan),
    .rx_pending_in(pend), .blocks_sent_in(ev[0]), .blocks_recv_in(ev[1]),
    .blocks_parsed_in(ev[2]), .block_error_in(ev[3]), .rx_char_in(ev[4]),
    .rx_block_in(ev[5]), .rx_state_in(rx_state), .rx_discard_in(ev[6]),
    .wr_start_in(wr_start), .wr_count_in(wr_count), .wr_gap_ms_in(wr_gap),
    .wr_data_in(wr_data), .tx_done_in(tx_done), .tx_req_out(tx_req),
    .tx_byte_out(tx_byte), .tx_busy_out(tx_busy), .image_out(image),
    .status_block_out(sblk), .seq_out(seq), .eff_term_type_out(),
    .eff_baud_out(baud), .eff_parity_out(), .eff_word_len_out(wlen),
    .eff_two_stop_out(two_stop), .eff_handshake_out(), .term_char_en_out(),
    .term_packet_en_out(), .term_timeout_en_out(), .term_gap_en_out(),
    .eff_wr_timeout_out(wr_to));
  serial_sink sink_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .tx_req_in(tx_req),
    .tx_byte_in(tx_byte), .tx_done_out(tx_done), .sent_out(sent), .count_out(cnt));

  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input [127:0] s, input [127:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      give_verdict;
    end
  endtask
  task pulse(input [6:0] m);
    @(posedge clk_in);
    ev <= m;
    @(posedge clk_in);
    ev <= 7'h00;
  endtask
  task do_scan;
    @(posedge clk_in);
    scan <= 1'b1;
    @(posedge clk_in);
    scan <= 1'b0;
    nscan++;
    eseq++;
    #1;
    chk(seq, eseq);
  endtask
  // The cycle word shows the number of scans made before this one.
  task scan_chk(input [7:0] len, input [95:0] w);
    reg [15:0] cyc;
    cyc = nscan[15:0];
    do_scan;
    chk(image, {w, cyc, len, eseq});
    chk(sblk, 1'b1);
  endtask

  task t_regs;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'b0, `OFF_ERR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
  endtask
  task t_cfg;
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, ca[i], cd[i]);
      apb(1'b0, `OFF_ERR, 32'h0);
      chk(rd, 32'h1 << cb[i]);
      chk({baud, wlen, two_stop, wr_to},
          {24'h2580, 4'h8, 1'b0, 16'h1388});
      apb(1'b1, ca[i], rv[ca[i][4:2]]);
      apb(1'b0, `OFF_ERR, 32'h0);
      chk(rd, 32'h0);
    end
    // Character and packet endings on: an overlong packet turns off only the packet ending.
    apb(1'b1, `OFF_CFG_FRAME, 32'h184e_4e03);
    apb(1'b1, `OFF_CFG_PACKET, 32'h1388_1001);
    apb(1'b0, `OFF_EFFECTIVE, 32'h0);
    chk(rd, 32'h00c0_8100);
    apb(1'b1, `OFF_CFG_RATE, 32'h0d00_2580);
    apb(1'b0, `OFF_ERR, 32'h0);
    chk(rd, 32'h00c0);
    for (int i = 1; i < 4; i++) apb(1'b1, 8'(4 * i), rv[i]);
  endtask
  task t_layouts;
    pulse(7'h3f);
    pulse(7'h13);
    pulse(7'h12);
    scan_chk(`LEN_STATUS_A, {16'h0, 16'h0, 16'h1, 16'h1, 16'h3, 16'h2});
    apb(1'b1, `OFF_CTRL, 32'h1);
    scan_chk(`LEN_STATUS_B, {16'h0, 16'h0, 16'h0, 16'h1, 16'h3, 16'h00a5});
  endtask
  task t_pending;
    reg [127:0] old;
    old = image;
    @(posedge clk_in);
    pend <= 1'b1;
    do_scan;
    chk({sblk, image}, {1'b0, old});
    @(posedge clk_in);
    pend <= 1'b0;
  endtask
  task t_overrun;
    apb(1'b1, `OFF_CTRL, 32'h0);
    pulse(7'h40);
    apb(1'b0, `OFF_ERR, 32'h0);
    chk(rd, 32'h8000);
    scan_chk(`LEN_STATUS_A, {16'h0, 16'h8000, 16'h1, 16'h1, 16'h3, 16'h2});
    apb(1'b1, `OFF_ERR, 32'h8000);
    apb(1'b0, `OFF_ERR, 32'h0);
    chk(rd, 32'h0);
  endtask
  task t_tx;
    int n;
    apb(1'b1, `OFF_CTRL, 32'h1);
    chk(image[7:0], eseq);
    @(posedge clk_in);
    wr_start <= 1'b1;
    @(posedge clk_in);
    wr_start <= 1'b0;
    repeat (3) @(posedge clk_in);
    wr_count <= 4'h2;
    wr_start <= 1'b1;
    @(posedge clk_in);
    wr_start <= 1'b0;
    do_scan;
    chk(image[127:112] != 16'h0, 1'b1);
    n = 0;
    while (tx_busy !== 1'b0 && n < 500) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 500) begin
      fails++;
      give_verdict;
    end
    #1;
    chk({cnt, sent[23:0]}, {8'h03, 24'h414243});
    scan_chk(`LEN_STATUS_B, {16'h0, 16'h1, 16'h3, 16'h1, 16'h3, 16'h00a5});
  endtask

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    {rst_n_in, psel, penable, pwrite, scan, pend, wr_start, ev} = '0;
    {paddr, pwdata, fails, checks_done, nscan, eseq} = '0;
    rx_state = 16'h00a5;
    wr_count = 4'h3;
    wr_gap = 8'h01;
    wr_data = 80'h434241;
    rv = '{`RST_CTRL, `RST_CFG_FRAME, `RST_CFG_RATE, `RST_CFG_PACKET, `RST_CFG_TIMING};
    ca = '{`OFF_CFG_RATE, `OFF_CFG_FRAME, `OFF_CFG_FRAME, `OFF_CFG_TIMING,
           `OFF_CFG_TIMING, `OFF_CFG_PACKET, `OFF_CFG_RATE, `OFF_CFG_FRAME,
           `OFF_CFG_FRAME, `OFF_CFG_FRAME};
    cd = '{32'h0100_1234, 32'h144e_4e00, 32'h484e_4e00, 32'h0064_0000,
           32'h0000_0064, 32'h0000_0001, 32'h0000_2580, 32'h184e_4e10,
           32'h184e_4100, 32'h1841_4e00};
    cb = '{8'h01, 8'h03, 8'h04, 8'h08, 8'h09, 8'h0a, 8'hff, 8'h00, 8'h02, 8'h05};
    // Entry 6 is a zero termination count outside character mode: no flag, so its
    // shift runs past every bit and expects zero.
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs;
    t_cfg;
    t_layouts;
    t_pending;
    t_overrun;
    t_tx;
    give_verdict;
  end
endmodule // status_block_builder_bench
